// *** rtl/in_sync.sv ***
// two-flop synchroniser bank for asynchronous handshake inputs
// assumes inputs come from another domain or pins; reset value given per bit
`timescale 1ns/1ns
module in_sync
    import rst_hs_pkg::*;
#(
    parameter int unsigned W = 6
) (
    input  wire logic         core_clk,   // core clock
    input  wire logic         rst_b,      // async reset, active low
    input  wire logic [W-1:0] rst_val,    // constant idle level per bit
    input  wire logic [W-1:0] async_in,   // asynchronous inputs
    output logic      [W-1:0] sync_out    // synchronised outputs
);

    logic [W-1:0] meta_reg;  // first stage, read only by second stage
    logic [W-1:0] sync_reg;  // second stage
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_next;

    ////////////////////////////////////////////////////////////////////////
    // next values
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // registers hold input xor rst_val, so idle levels are all zeros here
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next ^ rst_val;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg ^ rst_val;

endmodule : in_sync

// *** rtl/rst_entry_hs.sv ***
// reset entry handshake logic of the streaming subsystem
// assumes the controller follows the request/ready/accept order and
// holds each handshake level until it sees the answer
// Overview of operation
// - cold reset clears sticky and volatile state
// - warm reset keeps sticky bits only
// - resets accepted sync or async
// - cold ack low after cold action
// - warm ack low after warm action
// - ready only when all blocks prepared
// - no new notify until sequence done
// - in-reset status low, core clock sync
// - hot reset starts via link request
// - link request raises notify
// - sequence blocks then assert ready
// - hot reset: accept raises warm ready
// - warm ready leads to status low
`timescale 1ns/1ns
module rst_entry_hs
    import rst_hs_pkg::*;
(
    input  wire logic               core_clk,        // 50 MHz core clock
    input  wire logic               rst_b,           // async reset, active low
    input  wire logic               cold_rst_n,      // cold reset, active low
    input  wire logic               warm_rst_n,      // warm reset, active low
    input  wire logic               entry_req,       // reset entry request
    input  wire logic               accept_rdy,      // controller accepted notify
    input  wire logic               link_rst_req,    // link reset req from core
    input  wire logic               core_in_rst_n,   // hard core in-reset, low
    input  wire logic               stream_bus_reset_low, // stream bus reset
    input  wire logic [STATE_W-1:0] sticky_wr,       // sticky state load value
    input  wire logic               sticky_we,       // sticky load strobe
    output logic                    cold_ack_n,      // cold done, active low
    output logic                    warm_ack_n,      // warm done, active low
    output logic                    entry_rdy,       // reset entry ready
    output logic                    notify_req,      // reset-needed notice
    output logic                    warm_rst_rdy,    // warm ready to hard core
    output logic                    status_n,        // in reset, active low
    output logic [STATE_W-1:0]      sticky_q,        // sticky state
    output logic [STATE_W-1:0]      volatile_q       // non-sticky state
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    sync_in_t si;               // synchronised inputs
    logic [5:0] si_vec;         // flat view for the bank
    // idle levels: active-low resets idle high, so xor 1 makes reset value 1
    localparam logic [5:0] SYNC_IDLE = 6'h31;

    in_sync #(.W(6)) u_sync (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .rst_val  (SYNC_IDLE),
        .async_in ({cold_rst_n, warm_rst_n, entry_req, accept_rdy,
                    link_rst_req, core_in_rst_n}),
        .sync_out (si_vec)
    );
    assign si = sync_in_t'(si_vec);

    // either bus or warm reset counts as a warm action request
    logic bus_meta_reg;         // stream bus reset first stage
    logic bus_sync_reg;         // stream bus reset second stage

    ////////////////////////////////////////////////////////////////////////
    // state
    hs_state_t          st_reg, st_next;        // handshake state
    logic [BLK_COUNT-1:0] blk_rdy_reg, blk_rdy_next; // per-block prepared
    logic [3:0]         prep_cnt_reg, prep_cnt_next; // quiesce counter
    logic               hot_reg, hot_next;      // flow began from link req
    logic [3:0]         act_cnt_reg, act_cnt_next;   // reset action timer
    logic               cold_seen_reg, cold_seen_next; // cold action running
    logic               cold_ack_reg, cold_ack_next;
    logic               warm_ack_reg, warm_ack_next;
    logic               status_reg, status_next;
    logic [STATE_W-1:0] sticky_reg, sticky_next;
    logic [STATE_W-1:0] vol_reg, vol_next;
    logic               warm_any;               // any warm-class reset seen
    logic               entry_rdy_reg, entry_rdy_next;  // entry ready flop
    logic               notify_reg, notify_next;        // reset-needed flop
    logic               warm_rdy_reg, warm_rdy_next;    // warm ready flop

    // count helper used for both timers
    function automatic logic [3:0] sat_inc(input logic [3:0] v, input logic [3:0] m);
        sat_inc = (v >= m) ? m : 4'(v + 4'h1);
    endfunction : sat_inc

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        warm_any      = !si.warm_n || !bus_sync_reg;
        st_next       = st_reg;
        blk_rdy_next  = blk_rdy_reg;
        prep_cnt_next = prep_cnt_reg;
        hot_next      = hot_reg;
        act_cnt_next  = act_cnt_reg;
        cold_seen_next = cold_seen_reg;
        cold_ack_next = cold_ack_reg;
        warm_ack_next = warm_ack_reg;
        status_next   = si.core_rst_n;
        sticky_next   = sticky_we ? sticky_wr : sticky_reg;
        vol_next      = vol_reg + STATE_W'(1);

        unique case (st_reg)
            ST_IDLE: begin
                if (si.link_req) begin
                    st_next  = ST_NOTIFY;
                    hot_next = 1'b1;
                end else if (si.entry_req) begin        // user-started flow
                    st_next  = ST_PREP;
                    hot_next = 1'b0;
                end
                blk_rdy_next  = '0;
                prep_cnt_next = '0;
            end
            ST_NOTIFY: begin
                if (si.entry_req) st_next = ST_PREP;
            end
            ST_PREP: begin
                // blocks quiesce one after another, each taking a fixed time
                prep_cnt_next = sat_inc(prep_cnt_reg, PREP_CNT_MAX);
                if (prep_cnt_reg == PREP_CNT_MAX) begin
                    blk_rdy_next  = {blk_rdy_reg[BLK_COUNT-2:0], 1'b1};
                    prep_cnt_next = '0;
                end
                if (&blk_rdy_reg) st_next = ST_READY;
            end
            ST_READY: begin
                if (hot_reg && si.accept) st_next = ST_WARM_RDY;
                else if (!hot_reg && (warm_any || !si.cold_n)) st_next = ST_DONE;
            end
            ST_WARM_RDY: begin
                if (warm_any || !si.cold_n) st_next = ST_DONE;
            end
            ST_DONE: begin
                // sequence ends only when controller has dropped everything
                if (si.cold_n && !warm_any && !si.entry_req && !si.accept
                    && !si.link_req) begin
                    st_next  = ST_IDLE;
                    hot_next = 1'b0;
                end
            end
        endcase

        // reset actions run independently of the handshake state
        if (!si.cold_n) begin
            cold_seen_next = 1'b1;
            act_cnt_next   = sat_inc(act_cnt_reg, RST_ACT_MAX);
            sticky_next    = STICKY_RST;
            vol_next       = VOLATILE_RST;
            if (act_cnt_reg == RST_ACT_MAX) begin
                cold_ack_next = 1'b0;
                warm_ack_next = 1'b0;
            end
        end else if (warm_any) begin
            cold_seen_next = 1'b0;
            act_cnt_next   = sat_inc(act_cnt_reg, RST_ACT_MAX);
            vol_next       = VOLATILE_RST;
            cold_ack_next  = ACK_N_RST;
            if (act_cnt_reg == RST_ACT_MAX) warm_ack_next = 1'b0;
        end else begin
            cold_seen_next = 1'b0;
            act_cnt_next   = '0;
            cold_ack_next  = ACK_N_RST;
            warm_ack_next  = ACK_N_RST;
        end

        // handshake outputs decoded from the next state, so they leave a flop
        // with the same timing as a decode of the state register
        entry_rdy_next = (st_next == ST_READY) || (st_next == ST_WARM_RDY)
                         || (st_next == ST_DONE);
        notify_next    = (st_next == ST_NOTIFY)
                         || (hot_next && st_next != ST_IDLE);
        warm_rdy_next  = (st_next == ST_WARM_RDY)
                         || (hot_next && st_next == ST_DONE);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg        <= ST_IDLE;
            blk_rdy_reg   <= '0;
            prep_cnt_reg  <= '0;
            hot_reg       <= 1'b0;
            act_cnt_reg   <= '0;
            cold_seen_reg <= 1'b0;
            cold_ack_reg  <= ACK_N_RST;
            warm_ack_reg  <= ACK_N_RST;
            status_reg    <= STATUS_RST;
            sticky_reg    <= STICKY_RST;
            vol_reg       <= VOLATILE_RST;
            entry_rdy_reg <= 1'b0;
            notify_reg    <= 1'b0;
            warm_rdy_reg  <= 1'b0;
            bus_meta_reg  <= 1'b1;
            bus_sync_reg  <= 1'b1;
        end else begin
            st_reg        <= st_next;
            blk_rdy_reg   <= blk_rdy_next;
            prep_cnt_reg  <= prep_cnt_next;
            hot_reg       <= hot_next;
            act_cnt_reg   <= act_cnt_next;
            cold_seen_reg <= cold_seen_next;
            cold_ack_reg  <= cold_ack_next;
            warm_ack_reg  <= warm_ack_next;
            status_reg    <= status_next;
            sticky_reg    <= sticky_next;
            vol_reg       <= vol_next;
            entry_rdy_reg <= entry_rdy_next;
            notify_reg    <= notify_next;
            warm_rdy_reg  <= warm_rdy_next;
            bus_meta_reg  <= stream_bus_reset_low;
            bus_sync_reg  <= bus_meta_reg;
        end
    end

    // outputs straight from flops; no glitches reach the controller
    assign cold_ack_n   = cold_ack_reg;
    assign warm_ack_n   = warm_ack_reg;
    assign entry_rdy    = entry_rdy_reg;
    assign notify_req   = notify_reg;
    assign warm_rst_rdy = warm_rdy_reg;
    assign status_n     = status_reg;
    assign sticky_q     = sticky_reg;
    assign volatile_q   = vol_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    AST_READY_ALL: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(entry_rdy) |-> &$past(blk_rdy_reg)) else $error("ready early");
    // notification only drops on the way out of the finished sequence
    AST_NO_RENOTIFY: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(notify_req) |-> $past(st_reg) == ST_DONE) else $error("renotify");
    AST_NOTIFY: assert property (@(posedge core_clk) disable iff (!rst_b)
        (st_reg == ST_IDLE && si.link_req) |=> notify_req) else $error("no notify");
    AST_WARM_RDY: assert property (@(posedge core_clk) disable iff (!rst_b)
        (st_reg == ST_READY && hot_reg && si.accept) |=> warm_rst_rdy)
        else $error("no warm ready");
    AST_COLD_ACK: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(cold_ack_n) |-> !$past(si.cold_n)) else $error("cold ack");
    AST_WARM_ACK: assert property (@(posedge core_clk) disable iff (!rst_b)
        $fell(warm_ack_n) |-> $past(act_cnt_reg) == RST_ACT_MAX) else $error("warm ack");
    AST_STICKY_KEEP: assert property (@(posedge core_clk) disable iff (!rst_b)
        (si.cold_n && warm_any && !sticky_we) |=> $stable(sticky_q)) else $error("sticky");
    AST_COLD_CLR: assert property (@(posedge core_clk) disable iff (!rst_b)
        !si.cold_n |=> sticky_q == STICKY_RST) else $error("cold clear");
    AST_STATUS: assert property (@(posedge core_clk) disable iff (!rst_b)
        1'b1 |=> status_n == $past(si.core_rst_n)) else $error("status");
    CV_HOT: cover property (@(posedge core_clk) disable iff (!rst_b) $rose(warm_rst_rdy));
    CV_USER: cover property (@(posedge core_clk) disable iff (!rst_b)
        $rose(entry_rdy) && !hot_reg);
    CV_COLD: cover property (@(posedge core_clk) disable iff (!rst_b) $fell(cold_ack_n));

endmodule : rst_entry_hs

// *** rtl/rst_hs_pkg.sv ***
// package for the subsystem reset entry handshake block
// assumes one core clock; all handshake pins arrive asynchronously
package rst_hs_pkg;

    // number of internal blocks that must agree before reset entry
    localparam int unsigned BLK_COUNT  = 4;
    // synchroniser depth for every asynchronous input
    localparam int unsigned SYNC_DEPTH = 2;
    // cycles an internal block needs to quiesce after a prepare request
    localparam int unsigned PREP_CYCLES = 3;
    localparam logic [3:0]  PREP_CNT_MAX = 4'(PREP_CYCLES);
    // cycles the cold/warm action takes once the reset input is seen
    localparam int unsigned RST_ACT_CYCLES = 4;
    localparam logic [3:0]  RST_ACT_MAX    = 4'(RST_ACT_CYCLES);
    // reset values of the handshake outputs
    localparam logic        ACK_N_RST  = 1'b1;
    localparam logic        STATUS_RST = 1'b0;
    // width of the sticky and non-sticky state held by this block
    localparam int unsigned STATE_W      = 8;
    localparam logic [7:0]  STICKY_RST   = 8'h00;
    localparam logic [7:0]  VOLATILE_RST = 8'h00;

    // synchronised inputs, grouped
    typedef struct packed {
        logic cold_n;      // cold reset input, low = asserted
        logic warm_n;      // warm reset input, low = asserted
        logic entry_req;   // reset entry request
        logic accept;      // controller accepted the notification
        logic link_req;    // link reset request from the hard core
        logic core_rst_n;  // in-reset level from the hard core
    } sync_in_t;

    // entry handshake states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_NOTIFY,
        ST_PREP,
        ST_READY,
        ST_WARM_RDY,
        ST_DONE
    } hs_state_t;

endpackage : rst_hs_pkg

// *** test/rst_ctl_model.sv ***
// behavioural model of the application-side reset controller
// assumes the bench calls enter and then leave, at a falling clock edge
`timescale 1ns/1ns
module rst_ctl_model (
    input  wire logic core_clk,             // core clock
    input  wire logic cold_ack_n,           // cold done, low
    input  wire logic warm_ack_n,           // warm done, low
    input  wire logic entry_rdy,            // reset entry ready
    input  wire logic notify_req,           // reset-needed notice
    input  wire logic warm_rst_rdy,         // warm ready to hard core
    output logic      cold_rst_n,           // cold reset, low
    output logic      warm_rst_n,           // warm reset, low
    output logic      stream_bus_reset_low, // stream bus reset, low
    output logic      entry_req,            // reset entry request
    output logic      accept_rdy,           // accept handshake
    output int        rdy_wait,             // cycles from request to ready
    output logic      timed_out             // a bounded wait ran out
);
    ////////////////////////////////////////////////////////////////////////
    // idle levels from time zero
    initial begin
        cold_rst_n           = 1'b1;
        warm_rst_n           = 1'b1;
        stream_bus_reset_low = 1'b1;
        entry_req            = 1'b0;
        accept_rdy           = 1'b0;
        rdy_wait             = 0;
        timed_out            = 1'b0;
    end

    // handshake levels looked at only on falling edges, long after they settle
    function automatic logic pick(input int k);
        case (k)
            0:       pick = notify_req;
            1:       pick = entry_rdy;
            2:       pick = warm_rst_rdy;
            3:       pick = !warm_ack_n;
            default: pick = !cold_ack_n;
        endcase
    endfunction : pick

    // bounded wait; a stuck device flags instead of hanging the run
    task automatic wait_for(input int k, output int n);
        n = 0;
        while (!pick(k) && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 200) timed_out = 1'b1;
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////////
    // mode 0 hot reset, 1 user cold, 2 user warm
    task automatic enter(input int mode);
        int n;
        if (mode == 0) wait_for(0, n);
        entry_req = 1'b1;
        wait_for(1, rdy_wait);
        if (mode == 0) begin
            accept_rdy = 1'b1;
            wait_for(2, n);
        end
        if (mode == 1) cold_rst_n = 1'b0;
        warm_rst_n           = 1'b0;
        stream_bus_reset_low = 1'b0;
        wait_for((mode == 1) ? 4 : 3, n);
    endtask : enter

    // resets first, then the request levels
    task automatic leave();
        @(negedge core_clk);
        cold_rst_n           = 1'b1;
        warm_rst_n           = 1'b1;
        stream_bus_reset_low = 1'b1;
        @(negedge core_clk);
        entry_req  = 1'b0;
        accept_rdy = 1'b0;
    endtask : leave
endmodule : rst_ctl_model

// *** test/rst_entry_hs_tb.sv ***
// self-checking bench for the reset entry handshake block
// assumes the controller model beside it; hard core pins driven here
`timescale 1ns/1ns
module rst_entry_hs_tb;
    import rst_hs_pkg::*;
    logic               core_clk, rst_b, link_rst_req, core_in_rst_n, sticky_we;
    logic [STATE_W-1:0] sticky_wr, sticky_q, volatile_q;
    logic               cold_rst_n, warm_rst_n, stream_bus_reset_low, entry_req, accept_rdy;
    logic               cold_ack_n, warm_ack_n, entry_rdy, notify_req, warm_rst_rdy, status_n;
    logic               timed_out;  // model wait ran out
    int                 rdy_wait;   // request-to-ready cycles
    int                 num_errors, comparisons;

    rst_entry_hs uut (.core_clk(core_clk), .rst_b(rst_b), .cold_rst_n(cold_rst_n),
        .warm_rst_n(warm_rst_n), .entry_req(entry_req), .accept_rdy(accept_rdy),
        .link_rst_req(link_rst_req), .core_in_rst_n(core_in_rst_n),
        .stream_bus_reset_low(stream_bus_reset_low), .sticky_wr(sticky_wr),
        .sticky_we(sticky_we), .cold_ack_n(cold_ack_n), .warm_ack_n(warm_ack_n),
        .entry_rdy(entry_rdy), .notify_req(notify_req), .warm_rst_rdy(warm_rst_rdy),
        .status_n(status_n), .sticky_q(sticky_q), .volatile_q(volatile_q));

    rst_ctl_model ctl (.core_clk(core_clk), .cold_ack_n(cold_ack_n),
        .warm_ack_n(warm_ack_n), .entry_rdy(entry_rdy), .notify_req(notify_req),
        .warm_rst_rdy(warm_rst_rdy), .cold_rst_n(cold_rst_n), .warm_rst_n(warm_rst_n),
        .stream_bus_reset_low(stream_bus_reset_low), .entry_req(entry_req),
        .accept_rdy(accept_rdy), .rdy_wait(rdy_wait), .timed_out(timed_out));

    ////////////////////////////////////////////////////////////////////////
    // 50 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic close_out();
        $display("checks %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // a flow that stalled goes straight to the verdict
    task automatic flow_ok();
        chk(timed_out, 1'b0, "flow stalled");
        if (timed_out !== 1'b0) close_out();
    endtask : flow_ok

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic load_sticky(input logic [7:0] v);
        sticky_wr = v;
        sticky_we = 1'b1;
        cyc(1);
        sticky_we = 1'b0;
        cyc(1);
    endtask : load_sticky

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(cold_ack_n, ACK_N_RST, "cold ack idle");
        chk(warm_ack_n, ACK_N_RST, "warm ack idle");
        chk({entry_rdy, notify_req, warm_rst_rdy}, 8'h00, "handshake idle");
        chk(sticky_q, STICKY_RST, "sticky reset");
        chk(status_n, 1'b1, "status follows core");
        $display("test reset done");
    endtask : t_reset

    // link request, notify, entry, accept, warm ready, warm reset, release
    task automatic t_hot();
        load_sticky(8'hA5);
        link_rst_req = 1'b1;
        ctl.enter(0);
        flow_ok();
        chk(rdy_wait >= BLK_COUNT * (PREP_CYCLES + 1), 1'b1, "ready early");
        core_in_rst_n = 1'b0;
        cyc(4);
        chk(status_n, 1'b0, "status in reset");
        chk(warm_ack_n, 1'b0, "warm ack");
        chk(cold_ack_n, 1'b1, "no cold ack");
        chk(sticky_q, 8'hA5, "sticky kept");
        chk(volatile_q, VOLATILE_RST, "volatile cleared");
        chk(notify_req, 1'b1, "notify held");
        link_rst_req  = 1'b0;
        core_in_rst_n = 1'b1;
        ctl.leave();
        cyc(6);
        chk({notify_req, warm_rst_rdy, entry_rdy}, 8'h00, "flow ended");
        chk(warm_ack_n, 1'b1, "warm ack released");
        chk(status_n, 1'b1, "status out of reset");
        $display("test hot reset done");
    endtask : t_hot

    task automatic t_user(input int mode, input logic [7:0] v);
        load_sticky(v);
        ctl.enter(mode);
        flow_ok();
        chk(notify_req, 1'b0, "no notify");
        chk(warm_rst_rdy, 1'b0, "warm ready hot only");
        chk(warm_ack_n, 1'b0, "warm ack");
        chk(cold_ack_n, (mode == 1) ? 1'b0 : 1'b1, "cold ack");
        chk(sticky_q, (mode == 1) ? STICKY_RST : v, "sticky");
        chk(volatile_q, VOLATILE_RST, "volatile cleared");
        ctl.leave();
        cyc(6);
        chk({cold_ack_n, warm_ack_n, entry_rdy}, 8'h06, "released");
        $display("test user mode %0d done", mode);
    endtask : t_user

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_b         = 1'b0;
        link_rst_req  = 1'b0;
        core_in_rst_n = 1'b1;
        sticky_we     = 1'b0;
        sticky_wr     = 8'h00;
        num_errors    = 0;
        comparisons   = 0;
        repeat (12) @(negedge core_clk);
        chk(status_n, STATUS_RST, "status during reset");
        rst_b = 1'b1;
        cyc(4);
        t_reset();
        t_hot();
        t_user(1, 8'h5A);
        t_user(2, 8'h3C);
        close_out();
    end
endmodule : rst_entry_hs_tb
